// >>> rtl/acmpc_pkg.sv
// package: register map, field positions and timing counts of the comparator control block
package acmpc_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'hac;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'hb0;
	localparam logic [7:0] IRQ_CLEAR_ADDR = 8'hb1;
	localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hb2;
	localparam logic [7:0] SETTLE_STATUS_ADDR = 8'hb3;
	localparam int HYST_BIT = 6;
	localparam int ENABLE_BIT = 5;
	localparam int NEG_SEL_BIT = 3;
	localparam int PIN_OE_BIT = 2;
	localparam int RESULT_BIT = 1;
	localparam int FLAG_BIT = 0;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h6c;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int IRQ_CHANGE_BIT = 0;
	localparam int IRQ_SETTLED_BIT = 1;
	localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;
	localparam int CLK_MHZ = 250;
	localparam int SETTLE_US = 10;
	localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
	typedef struct packed {
		logic hysteresis_on;
		logic comparator_on;
		logic negative_input_select;
		logic pin_output_enable;
	} acmpc_ctrl_t;
endpackage

// >>> rtl/acmpc_sync.sv
// module: two-stage synchroniser with change pulse for the comparator result
`timescale 1ns/1ps
module acmpc_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic enable,
	input wire logic async_in,
	output logic synced,
	output logic changed
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	// forced low while off so a later enable edge is seen as a change only if the input is high
	always_ff @(posedge clk) begin
		if (srst) begin
			prev_q <= 1'b0;
		end else if (!enable) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sync_q;
		end
	end

	assign synced = enable & sync_q;
	assign changed = enable & (sync_q ^ prev_q);
endmodule

// >>> rtl/acmpc_settle.sv
// module: settle timer that counts the comparator start-up time after enable
`timescale 1ns/1ps
module acmpc_settle #(
	parameter int CYCLES = acmpc_pkg::SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic enable,
	output logic settled,
	output logic done_pulse
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count_q;

	always_ff @(posedge clk) begin
		if (srst || !enable) begin
			count_q <= '0;
		end else if (count_q != CW'(CYCLES)) begin
			count_q <= count_q + 1'b1;
		end
	end

	assign settled = (count_q == CW'(CYCLES));
	assign done_pulse = enable && (count_q == CW'(CYCLES - 1));
endmodule

// >>> rtl/acmpc_top.sv
// module: control, status and interrupt logic of comparator one
// Notes on behaviour
// - hysteresis control follows control bit 6; zero means off
// - control bit 3 picks negative input: 0 reference pin, 1 internal reference
// - result reaches output pin when bit 2 set and comparator on
// - output pin carries the raw comparator signal, not clock aligned
// - bit 1 reads result synchronised to the cpu clock, read only
// - synchronised result bit reads zero while comparator is off
// - change flag bit 0 sets on every result transition, either direction
// - change flag requests an interrupt whenever set; the interrupt enable register does not gate it
// - software clears flag by writing; disabling comparator clears it too
`timescale 1ns/1ps
module acmpc_top #(
	parameter int SETTLE_CYCLES = acmpc_pkg::SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic compare_raw,
	output logic hysteresis_on,
	output logic comparator_on,
	output logic negative_input_select,
	output logic comparator_one_output,
	output logic comparator_one_output_oe,
	output logic compare_change_irq,
	output logic irq
);
	acmpc_pkg::acmpc_ctrl_t ctrl_q;
	logic flag_q;
	logic [1:0] irq_status_q;
	logic [1:0] irq_enable_q;
	logic [7:0] rdata_q;
	logic synced_compare_result;
	logic result_changed;
	logic settled;
	logic settle_done;
	logic wr_ctrl;
	logic wr_clear;
	logic [7:0] ctrl_view;

	assign wr_ctrl = wr_en && (addr == acmpc_pkg::CTRL_ADDR);
	assign wr_clear = wr_en && (addr == acmpc_pkg::IRQ_CLEAR_ADDR);

	acmpc_sync u_sync (
		.clk(clk),
		.srst(srst),
		.enable(ctrl_q.comparator_on),
		.async_in(compare_raw),
		.synced(synced_compare_result),
		.changed(result_changed)
	);

	acmpc_settle #(
		.CYCLES(SETTLE_CYCLES)
	) u_settle (
		.clk(clk),
		.srst(srst),
		.enable(ctrl_q.comparator_on),
		.settled(settled),
		.done_pulse(settle_done)
	);

	// writable control fields; reserved bits and the result bit drop writes
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= '0;
		end else if (wr_ctrl) begin
			ctrl_q.hysteresis_on <= wdata[acmpc_pkg::HYST_BIT];
			ctrl_q.comparator_on <= wdata[acmpc_pkg::ENABLE_BIT];
			ctrl_q.negative_input_select <= wdata[acmpc_pkg::NEG_SEL_BIT];
			ctrl_q.pin_output_enable <= wdata[acmpc_pkg::PIN_OE_BIT];
		end
	end

	// change flag: disable clears first, then a new change beats a software clear
	always_ff @(posedge clk) begin
		if (srst) begin
			flag_q <= 1'b0;
		end else if (!ctrl_q.comparator_on) begin
			flag_q <= 1'b0;
		end else if (result_changed) begin
			flag_q <= 1'b1;
		end else if (wr_ctrl && !wdata[acmpc_pkg::FLAG_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	// sticky interrupt status: set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_status_q <= 2'h0;
		end else begin
			irq_status_q[acmpc_pkg::IRQ_CHANGE_BIT] <= result_changed
				| (irq_status_q[acmpc_pkg::IRQ_CHANGE_BIT]
				& ~(wr_clear & wdata[acmpc_pkg::IRQ_CHANGE_BIT]));
			irq_status_q[acmpc_pkg::IRQ_SETTLED_BIT] <= settle_done
				| (irq_status_q[acmpc_pkg::IRQ_SETTLED_BIT]
				& ~(wr_clear & wdata[acmpc_pkg::IRQ_SETTLED_BIT]));
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_enable_q <= acmpc_pkg::IRQ_ENABLE_RESET;
		end else if (wr_en && addr == acmpc_pkg::IRQ_ENABLE_ADDR) begin
			irq_enable_q <= wdata[1:0];
		end
	end

	always_comb begin
		ctrl_view = acmpc_pkg::CTRL_RESET;
		ctrl_view[acmpc_pkg::HYST_BIT] = ctrl_q.hysteresis_on;
		ctrl_view[acmpc_pkg::ENABLE_BIT] = ctrl_q.comparator_on;
		ctrl_view[acmpc_pkg::NEG_SEL_BIT] = ctrl_q.negative_input_select;
		ctrl_view[acmpc_pkg::PIN_OE_BIT] = ctrl_q.pin_output_enable;
		ctrl_view[acmpc_pkg::RESULT_BIT] = synced_compare_result;
		ctrl_view[acmpc_pkg::FLAG_BIT] = flag_q;
	end

	// read data valid only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				acmpc_pkg::CTRL_ADDR: rdata_q <= ctrl_view;
				acmpc_pkg::IRQ_STATUS_ADDR: rdata_q <= {6'h00, irq_status_q};
				acmpc_pkg::IRQ_ENABLE_ADDR: rdata_q <= {6'h00, irq_enable_q};
				acmpc_pkg::SETTLE_STATUS_ADDR: rdata_q <= {7'h00, settled};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata = rdata_q;

	// analog controls are straight register outputs
	assign hysteresis_on = ctrl_q.hysteresis_on;
	assign comparator_on = ctrl_q.comparator_on;
	assign negative_input_select = ctrl_q.negative_input_select;
	assign compare_change_irq = flag_q;
	assign irq = |(irq_status_q & irq_enable_q);

	// the pin must stay asynchronous, so the raw signal is gated, not registered
	assign comparator_one_output_oe = ctrl_q.pin_output_enable & ctrl_q.comparator_on;
	assign comparator_one_output = comparator_one_output_oe & compare_raw;
endmodule

// >>> tb/acmpc_monitor.sv
// checker: port-level assertions of the comparator control block
`timescale 1ns/1ps
module acmpc_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic compare_raw,
	input wire logic hysteresis_on,
	input wire logic comparator_on,
	input wire logic negative_input_select,
	input wire logic comparator_one_output,
	input wire logic comparator_one_output_oe,
	input wire logic compare_change_irq,
	input wire logic irq
);
	logic wr_ctl;
	logic rd_ctl;
	assign wr_ctl = wr_en && addr == acmpc_pkg::CTRL_ADDR;
	assign rd_ctl = rd_en && addr == acmpc_pkg::CTRL_ADDR;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	a_ctrl_write: assert property (
		wr_ctl |=> {hysteresis_on, comparator_on, negative_input_select}
			== $past({wdata[6], wdata[5], wdata[3]})) else $error("control write lost");
	a_pin_gate: assert property (
		comparator_one_output_oe |-> comparator_on) else $error("pin on while off");
	a_pin_raw: assert property (
		comparator_one_output == (compare_raw && comparator_one_output_oe)) else $error("pin");
	a_flag_off: assert property (
		!comparator_on [*2] |-> !compare_change_irq) else $error("flag kept while off");
	// sticky flag, so one look after the window is enough
	a_flag_set: assert property (
		comparator_on && $changed(compare_raw) ##1 (comparator_on && $stable(compare_raw)) [*3]
			|=> compare_change_irq) else $error("change not flagged");
	a_rdata_idle: assert property (
		!$past(rd_en) |-> rdata == 8'h00) else $error("read data outside read");
	a_ctrl_read: assert property (
		$past(rd_ctl) |-> !rdata[7] && !rdata[4]
			&& rdata[6:5] == $past({hysteresis_on, comparator_on})) else $error("ctrl read");
	a_result_off: assert property (
		$past(rd_ctl && !comparator_on) |-> rdata[1:0] == 2'h0) else $error("result while off");
endmodule
bind acmpc_top acmpc_monitor mon (.*);

// >>> tb/acmpc_core_model.sv
// model: analog comparator core with selectable negative reference
`timescale 1ns/1ps
module acmpc_core_model #(
	parameter int VREF_MV = 300,
	parameter int HYST_MV = 20
) (
	input wire logic on,
	input wire logic hyst,
	input wire logic nsel,
	input wire logic signed [31:0] pos_mv,
	input wire logic signed [31:0] ext_mv,
	output logic raw
);
	// once high the trip point drops, so a slow input does not chatter
	always @(on, hyst, nsel, pos_mv, ext_mv)
		raw = on && pos_mv > (nsel ? VREF_MV : ext_mv) - ((hyst && raw) ? HYST_MV : 0);
endmodule

// >>> tb/testbench.sv
// testbench: register, pin and interrupt scenarios of comparator one
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module testbench;
	logic clk = 0, srst = 1, wr_en = 0, rd_en = 0, compare_raw, irq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic hysteresis_on, comparator_on, negative_input_select;
	logic comparator_one_output, comparator_one_output_oe, compare_change_irq;
	int pos_mv = 100, ext_mv = 500, n_fail = 0, checks_done = 0;
	localparam logic [7:0] ctl = acmpc_pkg::CTRL_ADDR;
	always #2 clk = ~clk;
	acmpc_top #(.SETTLE_CYCLES(20)) dut (.*);
	acmpc_core_model core (.on(comparator_on), .hyst(hysteresis_on),
		.nsel(negative_input_select), .pos_mv(pos_mv), .ext_mv(ext_mv), .raw(compare_raw));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 `CHK(rdata, exp)
	endtask
	task automatic settle(input int mv);
		@(posedge clk);
		pos_mv <= mv;
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic t_regs;
		wr(ctl, 8'hff);
		`CHK({hysteresis_on, comparator_on, negative_input_select, comparator_one_output_oe}, 4'hf)
		rd(ctl, 8'h6c);
		rd(8'h00, 8'h00);
		wr(ctl, 8'h00);
		rd(ctl, 8'h00);
	endtask
	task automatic t_change;
		wr(ctl, 8'h2c);
		wr(acmpc_pkg::IRQ_ENABLE_ADDR, 8'h01);
		settle(400);
		`CHK({comparator_one_output, compare_change_irq, irq}, 3'h7)
		rd(ctl, 8'h2f);
		wr(ctl, 8'h2e);
		`CHK(compare_change_irq, 1'b0)
		wr(acmpc_pkg::IRQ_CLEAR_ADDR, 8'h01);
		`CHK(irq, 1'b0)
		wr(acmpc_pkg::IRQ_ENABLE_ADDR, 8'h00);
		settle(100);
		`CHK({comparator_one_output, compare_change_irq, irq}, 3'h2)
		rd(ctl, 8'h2d);
		wr(ctl, 8'h00);
		`CHK(compare_change_irq, 1'b0)
		rd(ctl, 8'h00);
	endtask
	// settle interrupt, external reference path and hysteresis hold
	task automatic t_misc;
		wr(acmpc_pkg::IRQ_CLEAR_ADDR, 8'h03);
		wr(ctl, 8'h20);
		rd(acmpc_pkg::SETTLE_STATUS_ADDR, 8'h00);
		repeat (24) @(posedge clk);
		rd(acmpc_pkg::SETTLE_STATUS_ADDR, 8'h01);
		rd(acmpc_pkg::IRQ_STATUS_ADDR, 8'h02);
		@(posedge clk);
		ext_mv <= 50;
		repeat (6) @(posedge clk);
		rd(ctl, 8'h23);
		wr(ctl, 8'h60);
		@(posedge clk);
		ext_mv <= 110;
		repeat (6) @(posedge clk);
		rd(ctl, 8'h62);
		wr(ctl, 8'h00);
		wr(acmpc_pkg::IRQ_ENABLE_ADDR, 8'h02);
		`CHK(irq, 1'b1)
		rd(acmpc_pkg::IRQ_ENABLE_ADDR, 8'h02);
		wr(acmpc_pkg::IRQ_CLEAR_ADDR, 8'h02);
		`CHK(irq, 1'b0)
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_change();
		t_misc();
		tally_and_finish();
	end
	initial begin
		#4000;
		n_fail++;
		tally_and_finish();
	end
endmodule
